// ---- inc/timer_pkg.sv ----
package timer_pkg;

    // Bus and counter widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 8;
    localparam int unsigned OFS_W  = 8;

    // Register byte offsets
    localparam logic [OFS_W-1:0] OFS_MODE       = 8'h00;
    localparam logic [OFS_W-1:0] OFS_PRESCALE   = 8'h04;
    localparam logic [OFS_W-1:0] OFS_MAIN       = 8'h08;
    localparam logic [OFS_W-1:0] OFS_SOURCE     = 8'h0C;
    localparam logic [OFS_W-1:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [OFS_W-1:0] OFS_IRQ_MASK   = 8'h14;
    localparam logic [OFS_W-1:0] OFS_PORT       = 8'h18;

    // Field positions
    localparam int unsigned MODE_RUN_BIT  = 0;
    localparam int unsigned MODE_POL_BIT  = 1;
    localparam int unsigned MODE_INV_BIT  = 2;
    localparam int unsigned IRQ_UFL_BIT   = 0;
    localparam int unsigned PORT_DATA_BIT = 0;
    localparam int unsigned PORT_DIR_BIT  = 1;
    localparam int unsigned PORT_PIN_BIT  = 2;
    localparam int unsigned SRC_LSB       = 0;
    localparam int unsigned SRC_MSB       = 1;

    // Reset values and divide-by-8 last count
    localparam logic [CNT_W-1:0] CNT_RESET = 8'hFF;
    localparam logic [2:0]       DIV_RESET = 3'h0;
    localparam logic [2:0]       DIV8_LAST = 3'h7;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        SRC_DIV1 = 2'h0,
        SRC_DIV2 = 2'h1,
        SRC_DIV8 = 2'h2,
        SRC_RING = 2'h3
    } count_src_t;

    typedef enum logic [1:0] {
        WR_IDLE  = 2'b00,
        WR_STAGE = 2'b01,
        WR_LOAD  = 2'b11
    } wr_phase_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] pend;
        wr_phase_t        phase;
    } stage_state_t;

    typedef struct packed {
        logic [2:0] div;
        logic       ring_q;
    } src_state_t;

    typedef struct packed {
        logic pulse_o;
        logic pulse_oe;
        logic inv_o;
        logic inv_oe;
    } pin_out_t;

endpackage

// ---- src/count_source_sel.sv ----
`timescale 1ns/10ps
module count_source_sel
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire timer_pkg::count_src_t src,
    input  wire logic                  ring_oscillator_clock,
    output logic                       tick
);
    import timer_pkg::*;

    src_state_t st_ff;
    src_state_t nxt_st;

    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.div    = st_ff.div + 3'h1;
        nxt_st.ring_q = ring_oscillator_clock;
        // One of four internal sources gives the count input
        unique case (src)
            SRC_DIV1: tick = 1'b1;
            SRC_DIV2: tick = st_ff.div[0];
            SRC_DIV8: tick = (st_ff.div == DIV8_LAST);
            SRC_RING: tick = ring_oscillator_clock & ~st_ff.ring_q;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= '{div: DIV_RESET, ring_q: 1'b0};
        else
            st_ff <= nxt_st;
    end

endmodule

// ---- src/reload_stage.sv ----
`timescale 1ns/10ps
module reload_stage
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    run,
    input  wire logic                    tick,
    input  wire logic                    wr,
    input  wire logic [timer_pkg::CNT_W-1:0] wdata,
    output logic [timer_pkg::CNT_W-1:0]      count,
    output logic                         underflow
);
    import timer_pkg::*;

    stage_state_t st_ff;
    stage_state_t nxt_st;

    always_comb
    begin
        nxt_st    = st_ff;
        underflow = 1'b0;
        if (!run)
        begin
            // Stopped: write goes to reload and counter together
            nxt_st.phase = WR_IDLE;
            if (wr)
            begin
                nxt_st.cnt    = wdata;
                nxt_st.reload = wdata;
            end
            else if (st_ff.phase != WR_IDLE)
            begin
                nxt_st.cnt    = st_ff.pend;
                nxt_st.reload = st_ff.pend;
            end
        end
        else if (wr)
        begin
            nxt_st.pend  = wdata;
            nxt_st.phase = WR_STAGE;
        end
        else if (tick)
        begin
            unique case (st_ff.phase)
                WR_IDLE:
                begin
                    if (st_ff.cnt == '0)
                    begin
                        underflow  = 1'b1;
                        nxt_st.cnt = st_ff.reload;
                    end
                    else
                        nxt_st.cnt = st_ff.cnt - 8'h01;
                end
                WR_STAGE:
                begin
                    nxt_st.reload = st_ff.pend;
                    nxt_st.phase  = WR_LOAD;
                end
                WR_LOAD:
                begin
                    nxt_st.cnt   = st_ff.reload;
                    nxt_st.phase = WR_IDLE;
                end
                default: nxt_st.phase = WR_IDLE;
            endcase
        end
    end

    assign count = st_ff.cnt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= '{cnt: CNT_RESET, reload: CNT_RESET, pend: CNT_RESET, phase: WR_IDLE};
        else
            st_ff <= nxt_st;
    end

endmodule

// ---- src/timer_pulse_output_mode.sv ----
`timescale 1ns/10ps
module timer_pulse_output_mode
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [timer_pkg::DATA_W-1:0] hwdata,
    input  wire logic                         hready,
    output logic [timer_pkg::DATA_W-1:0]      hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic                         ring_oscillator_clock,
    input  wire logic                         secondary_inverted_pin_i,
    output timer_pkg::pin_out_t               pins,
    output logic                              timer_irq
);
    import timer_pkg::*;

    typedef struct packed {
        logic                run;
        logic                pol;
        logic                inv_en;
        count_src_t          src;
        logic                irq_st;
        logic                irq_mask;
        logic                port_data;
        logic                port_dir;
        logic                pulse;
        logic                sec_o;
        logic                sec_oe;
        logic [OFS_W-1:0]    addr;
        logic                wr_pend;
        logic                rd_wait;
        logic                rd_done;
        logic [DATA_W-1:0]   rdata;
        logic                irq;
    } regs_t;

    regs_t st_ff;
    regs_t nxt_st;

    logic             src_tick;
    logic             pre_ufl;
    logic             main_ufl;
    logic [CNT_W-1:0] pre_count;
    logic [CNT_W-1:0] main_count;
    logic             wr_mode;
    logic             wr_pre;
    logic             wr_main;
    logic             wr_src;
    logic             wr_status;
    logic             wr_mask;
    logic             wr_port;
    logic             take;
    logic [DATA_W-1:0] rd_val;

    count_source_sel u_src
    (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .src                   (st_ff.src),
        .ring_oscillator_clock (ring_oscillator_clock),
        .tick                  (src_tick)
    );

    reload_stage u_prescaler
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .run       (st_ff.run),
        .tick      (src_tick),
        .wr        (wr_pre),
        .wdata     (hwdata[CNT_W-1:0]),
        .count     (pre_count),
        .underflow (pre_ufl)
    );

    // Main stage counts prescaler underflows
    reload_stage u_main
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .run       (st_ff.run),
        .tick      (pre_ufl),
        .wr        (wr_main),
        .wdata     (hwdata[CNT_W-1:0]),
        .count     (main_count),
        .underflow (main_ufl)
    );

    // Write strobes in the data phase
    always_comb
    begin
        wr_mode   = st_ff.wr_pend && (st_ff.addr == OFS_MODE);
        wr_pre    = st_ff.wr_pend && (st_ff.addr == OFS_PRESCALE);
        wr_main   = st_ff.wr_pend && (st_ff.addr == OFS_MAIN);
        wr_src    = st_ff.wr_pend && (st_ff.addr == OFS_SOURCE);
        wr_status = st_ff.wr_pend && (st_ff.addr == OFS_IRQ_STATUS);
        wr_mask   = st_ff.wr_pend && (st_ff.addr == OFS_IRQ_MASK);
        wr_port   = st_ff.wr_pend && (st_ff.addr == OFS_PORT);
    end

    // Address phase accepted
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Read data for the captured address
    always_comb
    begin
        rd_val = '0;
        unique case (st_ff.addr)
            OFS_MODE:
            begin
                rd_val[MODE_RUN_BIT] = st_ff.run;
                rd_val[MODE_POL_BIT] = st_ff.pol;
                rd_val[MODE_INV_BIT] = st_ff.inv_en;
            end
            OFS_PRESCALE:   rd_val[CNT_W-1:0] = pre_count;
            OFS_MAIN:       rd_val[CNT_W-1:0] = main_count;
            OFS_SOURCE:     rd_val[SRC_MSB:SRC_LSB] = st_ff.src;
            OFS_IRQ_STATUS: rd_val[IRQ_UFL_BIT] = st_ff.irq_st;
            OFS_IRQ_MASK:   rd_val[IRQ_UFL_BIT] = st_ff.irq_mask;
            OFS_PORT:
            begin
                rd_val[PORT_DATA_BIT] = st_ff.port_data;
                rd_val[PORT_DIR_BIT]  = st_ff.port_dir;
                rd_val[PORT_PIN_BIT]  = secondary_inverted_pin_i;
            end
            default: rd_val = '0;
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;

        // Bus pipeline: writes take no wait state, reads one
        nxt_st.wr_pend = 1'b0;
        nxt_st.rd_done = 1'b0;
        if (st_ff.rd_wait)
        begin
            nxt_st.rd_wait = 1'b0;
            nxt_st.rd_done = 1'b1;
            nxt_st.rdata   = rd_val;
        end
        else if (take)
        begin
            nxt_st.addr    = haddr[OFS_W-1:0];
            nxt_st.wr_pend = hwrite;
            nxt_st.rd_wait = ~hwrite;
        end

        // Mode register
        if (wr_mode)
        begin
            nxt_st.run    = hwdata[MODE_RUN_BIT];
            nxt_st.pol    = hwdata[MODE_POL_BIT];
            nxt_st.inv_en = hwdata[MODE_INV_BIT];
        end
        if (wr_src)
            nxt_st.src = count_src_t'(hwdata[SRC_MSB:SRC_LSB]);
        if (wr_mask)
            nxt_st.irq_mask = hwdata[IRQ_UFL_BIT];
        if (wr_port)
        begin
            nxt_st.port_data = hwdata[PORT_DATA_BIT];
            nxt_st.port_dir  = hwdata[PORT_DIR_BIT];
        end

        // Sticky underflow flag, set wins over clear
        if (wr_status && hwdata[IRQ_UFL_BIT])
            nxt_st.irq_st = 1'b0;
        if (main_ufl)
            nxt_st.irq_st = 1'b1;
        nxt_st.irq = nxt_st.irq_st & nxt_st.irq_mask;

        // Pulse output
        if (wr_main)
            nxt_st.pulse = st_ff.pol;
        else if (main_ufl && st_ff.run)
            nxt_st.pulse = ~st_ff.pulse;

        // Secondary pin: inverted pulse or plain port
        if (nxt_st.inv_en)
        begin
            nxt_st.sec_o  = ~nxt_st.pulse;
            nxt_st.sec_oe = 1'b1;
        end
        else
        begin
            nxt_st.sec_o  = nxt_st.port_data;
            nxt_st.sec_oe = nxt_st.port_dir;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '{
                run:       1'b0,
                pol:       1'b0,
                inv_en:    1'b0,
                src:       SRC_DIV1,
                irq_st:    1'b0,
                irq_mask:  1'b0,
                port_data: 1'b0,
                port_dir:  1'b0,
                pulse:     1'b0,
                sec_o:     1'b0,
                sec_oe:    1'b0,
                addr:      '0,
                wr_pend:   1'b0,
                rd_wait:   1'b0,
                rd_done:   1'b0,
                rdata:     RDATA_RESET,
                irq:       1'b0
            };
        end
        else
            st_ff <= nxt_st;
    end

    // Outputs
    assign hrdata    = st_ff.rdata;
    assign hreadyout = ~st_ff.rd_wait;
    assign hresp     = HRESP_OKAY;
    assign timer_irq = st_ff.irq;

    always_comb
    begin
        pins.pulse_o  = st_ff.pulse;
        pins.pulse_oe = 1'b1;
        pins.inv_o    = st_ff.sec_o;
        pins.inv_oe   = st_ff.sec_oe;
    end

endmodule

// ---- tb/timer_pulse_output_mode_checker.sv ----
`timescale 1ns/10ps
module timer_checker
    import timer_pkg::*;
(
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         hsel,
    input wire logic [31:0]                  haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic [timer_pkg::DATA_W-1:0] hwdata,
    input wire logic                         hready,
    input wire logic                         hreadyout,
    input wire logic                         hresp,
    input wire timer_pkg::pin_out_t          pins,
    input wire logic                         timer_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       ap_ff, aw_ff, run_ff, pol_ff, inv_ff, msk_ff, mwr_ff;
    logic [7:0] ao_ff;
    wire        take = hsel && hready && htrans == HTRANS_NONSEQ;
    wire        dwr  = hreadyout && ap_ff && aw_ff;
    // Shadow of the mode, mask and main-write events seen on the bus
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {ap_ff, aw_ff, run_ff, pol_ff, inv_ff, msk_ff, mwr_ff} <= 7'h00;
            ao_ff <= 8'h00;
        end
        else
        begin
            if (hreadyout)
            begin
                ap_ff <= take;
                aw_ff <= hwrite;
                ao_ff <= haddr[7:0];
            end
            mwr_ff <= dwr && ao_ff == OFS_MAIN;
            if (dwr && ao_ff == OFS_MODE)
                {inv_ff, pol_ff, run_ff} <= hwdata[2:0];
            if (dwr && ao_ff == OFS_IRQ_MASK)
                msk_ff <= hwdata[0];
        end
    end
    property p_hresp; hresp == HRESP_OKAY; endproperty
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
    property p_pulse_oe; pins.pulse_oe; endproperty
    property p_inv;
        inv_ff && $past(inv_ff) && $stable(pins.pulse_o) |-> pins.inv_oe && pins.inv_o == !pins.pulse_o;
    endproperty
    property p_force; mwr_ff |-> pins.pulse_o == pol_ff; endproperty
    property p_hold;
        !run_ff && !$past(run_ff) && !$past(run_ff, 2) && !mwr_ff |-> $stable(pins.pulse_o);
    endproperty
    property p_irq_tog;
        msk_ff && run_ff && !mwr_ff && $changed(pins.pulse_o) |-> ##[0:1] timer_irq;
    endproperty
    property p_irq_mask; !msk_ff && !$past(msk_ff) |-> !timer_irq; endproperty
    a_hresp: assert property (p_hresp) else $error("hresp not OKAY");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_pulse_oe: assert property (p_pulse_oe) else $error("pulse pin not driven");
    a_inv: assert property (p_inv) else $error("inverted pin wrong");
    a_force: assert property (p_force) else $error("start level not forced");
    a_hold: assert property (p_hold) else $error("pulse moved while stopped");
    a_irq_tog: assert property (p_irq_tog) else $error("no irq on underflow");
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");
    c_rd: cover property (take && !hwrite);
    c_tog: cover property (run_ff && $changed(pins.pulse_o));
    c_irq: cover property ($rose(timer_irq));
endmodule

// ---- tb/pin_load.sv ----
`timescale 1ns/10ps
module pin_load
(
    input  wire timer_pkg::pin_out_t pins,
    input  wire logic                ext_low,
    output logic                     sec_level
);
    // Secondary pin has a pull-up; the external load may pull it low when undriven
    assign sec_level = pins.inv_oe ? pins.inv_o : !ext_low;
endmodule

// ---- tb/timer_pulse_output_mode_tb.sv ----
`timescale 1ns/10ps
module timer_pulse_output_mode_tb;
    import timer_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ring = 0, ring_on = 0;
    logic        ext_low = 0, sec_level, hreadyout, hresp, timer_irq, lv;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    pin_out_t    pins;
    int          error_cnt = 0, tests_run = 0, seed = 32'h83494A26, n, m, p, src;
    int          divs[4] = '{1, 2, 8, 2};
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (ring_on) ring <= ~ring;
    timer_pulse_output_mode u_timer_pulse_output_mode (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ring_oscillator_clock(ring), .secondary_inverted_pin_i(sec_level),
        .pins(pins), .timer_irq(timer_irq));
    pin_load u_pin_load (.pins(pins), .ext_low(ext_low), .sec_level(sec_level));
    task close_out;
        $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            error_cnt++;
            close_out;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        chk("read", e, r);
    endtask
    task period(output int q);
        int k;
        @(negedge hclk);
        for (int s = 0; s < 2; s++)
        begin
            lv = pins.pulse_o;
            k = 0;
            while (pins.pulse_o === lv && k < 3000)
            begin
                @(negedge hclk);
                k++;
            end
            if (k >= 3000)
            begin
                error_cnt++;
                close_out;
            end
        end
        q = k;
    endtask
    initial
    begin
        #900000;
        error_cnt++;
        close_out;
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        chk("pulse_rst", 0, pins.pulse_o);
        rd(OFS_PRESCALE, 32'hFF);
        rd(OFS_MAIN, 32'hFF);
        rd(8'h1C, 32'h0);
        wr(OFS_IRQ_MASK, 1);
        for (src = 0; src < 4; src++)
        begin
            n = $random(seed) & 3;
            m = ($random(seed) & 3) + 1;
            ring_on <= (src == 3);
            wr(OFS_MODE, (src & 1) << 1);
            wr(OFS_SOURCE, src);
            wr(OFS_PRESCALE, n);
            wr(OFS_MAIN, m);
            wr(OFS_IRQ_STATUS, 1);
            rd(OFS_PRESCALE, n);
            rd(OFS_MAIN, m);
            chk("start_level", src & 1, pins.pulse_o);
            chk("irq_idle", 0, timer_irq);
            wr(OFS_MODE, 1 | ((src & 1) << 1) | ((src & 2) << 1));
            period(p);
            chk("period", divs[src] * (n + 1) * (m + 1), p);
            @(negedge hclk);
            chk("irq", 1, timer_irq);
            if (src > 1) chk("inv_pin", !pins.pulse_o, pins.inv_o);
            wr(OFS_MODE, 0);
            repeat (3) @(negedge hclk);
            lv = pins.pulse_o;
            repeat (200) @(negedge hclk);
            chk("hold", lv, pins.pulse_o);
        end
        wr(OFS_IRQ_STATUS, 1);
        repeat (2) @(negedge hclk);
        chk("irq_clr", 0, timer_irq);
        rd(OFS_IRQ_STATUS, 0);
        ring_on <= 0;
        wr(OFS_SOURCE, 0);
        wr(OFS_PRESCALE, 3);
        wr(OFS_MAIN, 3);
        wr(OFS_MODE, 1);
        period(p);
        chk("period_run", 16, p);
        wr(OFS_PRESCALE, 0);
        period(p);
        period(p);
        chk("period_new", 4, p);
        rd(OFS_PRESCALE, 0);
        wr(OFS_MODE, 0);
        wr(OFS_IRQ_MASK, 0);
        rd(OFS_IRQ_STATUS, 1);
        chk("irq_masked", 0, timer_irq);
        wr(OFS_PORT, 3);
        rd(OFS_PORT, 7);
        chk("inv_oe", 1, pins.inv_oe);
        wr(OFS_PORT, 2);
        rd(OFS_PORT, 2);
        wr(OFS_PORT, 0);
        ext_low <= 1;
        rd(OFS_PORT, 0);
        ext_low <= 0;
        rd(OFS_PORT, 4);
        close_out;
    end
endmodule
bind timer_pulse_output_mode timer_checker u_timer_checker (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .timer_irq(timer_irq));
